// >>> verilog/vic_pkg.sv
package vic_pkg;

	// ==========================================================
	// Source numbering: index equals default priority.
	// ==========================================================
	localparam int          VIC_NSRC       = 17;
	localparam int          VIC_IDX_W      = 5;
	localparam logic [4:0]  VIC_SRC_WDT    = 5'h00;
	localparam logic [4:0]  VIC_SRC_EXT0   = 5'h01;
	localparam logic [4:0]  VIC_SRC_KEY    = 5'h06;
	localparam logic [4:0]  VIC_SRC_I2C    = 5'h07;
	localparam logic [4:0]  VIC_SRC_BTM    = 5'h08;
	localparam logic [4:0]  VIC_SRC_ADC    = 5'h09;
	localparam logic [4:0]  VIC_SRC_NONE   = 5'h0A;
	localparam logic [4:0]  VIC_SRC_3W     = 5'h0B;
	localparam logic [4:0]  VIC_SRC_TMA    = 5'h0C;
	localparam logic [4:0]  VIC_SRC_TMB    = 5'h0D;
	localparam logic [4:0]  VIC_SRC_RXERR  = 5'h0E;
	localparam logic [4:0]  VIC_SRC_RXDONE = 5'h0F;
	localparam logic [4:0]  VIC_SRC_TXDONE = 5'h10;

	// ==========================================================
	// Vector addresses.
	// ==========================================================
	localparam logic [15:0] VIC_VEC_NMI    = 16'h0004;
	localparam logic [15:0] VIC_VEC_BASE   = 16'h0006;
	localparam logic [15:0] VIC_VEC_TRAP   = 16'h003E;
	localparam logic [15:0] VIC_VEC_RESET  = 16'h0000;

	// Kind of the vector being presented.
	typedef enum logic [1:0] {
		VIC_KIND_NONE = 2'b00,
		VIC_KIND_NMI  = 2'b01,
		VIC_KIND_MASK = 2'b10,
		VIC_KIND_TRAP = 2'b11
	} vic_kind_t;

	// Watchdog mode selection.
	typedef enum logic {
		VIC_WDT_INTERVAL = 1'b0,
		VIC_WDT_MODE1    = 1'b1
	} vic_wdt_mode_t;

	// Maps a maskable index onto its vector: the NMI vector for 0, base for 1, then 2 bytes a step.
	function automatic logic [15:0] vic_vector(input logic [4:0] idx);
		logic [15:0] v;
		if (idx == VIC_SRC_WDT) begin
			v = VIC_VEC_NMI;
		end else begin
			v = VIC_VEC_BASE + {10'h000, idx - 5'h01, 1'b0};
		end
		return v;
	endfunction

endpackage

// >>> verilog/vic_if.sv
`timescale 1ns/1ps
`default_nettype none

// Carries the pending picture from the top to the priority selector.
interface vic_sel_if;
	import vic_pkg::*;
	logic [VIC_NSRC-1:0] req;
	logic [VIC_NSRC-1:0] hi_grp;
	logic                found;
	logic [4:0]          idx;
	logic                idx_hi;
	modport top (output req, output hi_grp, input found, input idx, input idx_hi);
	modport sel (input req, input hi_grp, output found, output idx, output idx_hi);
endinterface

`default_nettype wire

// >>> verilog/vic_prio_sel.sv
`timescale 1ns/1ps
`default_nettype none

// Picks the eligible request: high group first, then lowest index.
module vic_prio_sel
	import vic_pkg::*;
(
	vic_sel_if.sel s
);

	// ==========================================================
	// Selection.
	// ==========================================================
	// Two passes keep the logic shallow; each pass scans from the lowest priority up
	// so that the last hit, the highest priority, wins.
	always_comb begin
		s.found  = 1'b0;
		s.idx    = 5'h00;
		s.idx_hi = 1'b0;
		for (int i = VIC_NSRC - 1; i >= 0; i--) begin
			if (s.req[i] && !s.hi_grp[i]) begin
				s.found = 1'b1;
				s.idx   = 5'(i);
			end
		end
		for (int i = VIC_NSRC - 1; i >= 0; i--) begin
			if (s.req[i] && s.hi_grp[i]) begin
				s.found  = 1'b1;
				s.idx    = 5'(i);
				s.idx_hi = 1'b1;
			end
		end
	end

endmodule // vic_prio_sel

`default_nettype wire

// >>> verilog/vic_top.sv
`timescale 1ns/1ps
`default_nettype none

module vic_top
	import vic_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        sys_rst_in,
	input  wire logic        wdt_mode_in,
	input  wire logic        watchdog_overflow_irq_in,
	input  wire logic [4:0]  external_edge_irqs_in,
	input  wire logic        key_input_irq_in,
	input  wire logic        i2c_transfer_done_irq_in,
	input  wire logic        basic_timer_match_irq_in,
	input  wire logic        adc_conversion_done_irq_in,
	input  wire logic        three_wire_transfer_done_irq_in,
	input  wire logic        timer_a_match_irq_in,
	input  wire logic        timer_b_match_irq_in,
	input  wire logic        async_rx_error_irq_in,
	input  wire logic        async_rx_done_irq_in,
	input  wire logic        async_tx_done_irq_in,
	input  wire logic        software_trap_instruction_in,
	input  wire logic        global_enable_flag_in,
	input  wire logic        in_service_level_flag_in,
	input  wire logic [16:0] mask_flag_in,
	input  wire logic [16:0] level_select_flag_in,
	input  wire logic        irq_ack_in,
	output logic             irq_req_out,
	output logic [1:0]       irq_kind_out,
	output logic [15:0]      irq_vector_out,
	output logic             irq_level_hi_out,
	output logic [16:0]      request_flags_out
);

	// ==========================================================
	// State.
	// ==========================================================
	typedef struct packed {
		logic [4:0]  ext_s1;
		logic [4:0]  ext_s2;
		logic [4:0]  ext_prev;
		logic [16:0] req_flag;
		logic        nmi_pend;
		logic        trap_pend;
		logic        req;
		logic [1:0]  kind;
		logic [15:0] vector;
		logic [4:0]  idx;
		logic        level_hi;
	} vic_state_t;

	localparam logic [16:0] VIC_ZERO17 = 17'h00000;
	localparam vic_state_t  VIC_RST = '{
		ext_s1: 5'h00, ext_s2: 5'h00, ext_prev: 5'h00, req_flag: VIC_ZERO17,
		nmi_pend: 1'b0, trap_pend: 1'b0, req: 1'b0, kind: VIC_KIND_NONE,
		vector: VIC_VEC_RESET, idx: 5'h00, level_hi: 1'b0};

	vic_state_t          st_q;
	vic_state_t          st_d;
	logic [VIC_NSRC-1:0] trig;
	logic [VIC_NSRC-1:0] eligible;
	logic [4:0]          ext_rise;
	logic                wdt_nmi;
	logic                ack_mask;

	vic_sel_if sel_bus ();

	vic_prio_sel u_sel (
		.s (sel_bus.sel)
	);

	// ==========================================================
	// Triggers.
	// ==========================================================
	// External pins are edge detected after a two-stage synchroniser; the first
	// stage feeds nothing but the second. Only rising edges are taken, since the
	// edge-sense selection lies outside this block.
	assign ext_rise = st_q.ext_s2 & ~st_q.ext_prev;

	// Watchdog overflow goes to exactly one path depending on the mode.
	assign wdt_nmi = watchdog_overflow_irq_in && (wdt_mode_in == VIC_WDT_MODE1);

	always_comb begin
		trig                 = VIC_ZERO17;
		trig[VIC_SRC_WDT]    = watchdog_overflow_irq_in && (wdt_mode_in == VIC_WDT_INTERVAL);
		trig[VIC_SRC_EXT0+:5] = ext_rise;
		trig[VIC_SRC_KEY]    = key_input_irq_in;
		trig[VIC_SRC_I2C]    = i2c_transfer_done_irq_in;
		trig[VIC_SRC_BTM]    = basic_timer_match_irq_in;
		trig[VIC_SRC_ADC]    = adc_conversion_done_irq_in;
		trig[VIC_SRC_NONE]   = 1'b0;
		trig[VIC_SRC_3W]     = three_wire_transfer_done_irq_in;
		trig[VIC_SRC_TMA]    = timer_a_match_irq_in;
		trig[VIC_SRC_TMB]    = timer_b_match_irq_in;
		trig[VIC_SRC_RXERR]  = async_rx_error_irq_in;
		trig[VIC_SRC_RXDONE] = async_rx_done_irq_in;
		trig[VIC_SRC_TXDONE] = async_tx_done_irq_in;
	end

	// ==========================================================
	// Eligibility.
	// ==========================================================
	// A flag counts when unmasked and globally enabled; while a high level is in
	// service, low-group requests wait until it returns.
	always_comb begin
		for (int i = 0; i < VIC_NSRC; i++) begin
			eligible[i] = st_q.req_flag[i] && !mask_flag_in[i] && global_enable_flag_in
			              && !(in_service_level_flag_in && !level_select_flag_in[i]);
		end
	end

	assign sel_bus.req    = eligible;
	assign sel_bus.hi_grp = level_select_flag_in;

	// ==========================================================
	// Next state.
	// ==========================================================
	// A presented vector stays until the core acknowledges; the choice is frozen
	// meanwhile so the vector cannot change under the core.
	always_comb begin
		st_d          = st_q;
		ack_mask      = 1'b0;
		st_d.ext_s1   = external_edge_irqs_in;
		st_d.ext_s2   = st_q.ext_s1;
		st_d.ext_prev = st_q.ext_s2;
		if (st_q.req && irq_ack_in) begin
			st_d.req = 1'b0;
			case (st_q.kind)
				VIC_KIND_NMI:  st_d.nmi_pend  = 1'b0;
				VIC_KIND_TRAP: st_d.trap_pend = 1'b0;
				VIC_KIND_MASK: ack_mask       = 1'b1;
				default:       st_d.req       = 1'b0;
			endcase
		end
		// Acknowledge clears a flag, but a new trigger in that same cycle wins.
		for (int i = 0; i < VIC_NSRC; i++) begin
			if (ack_mask && (st_q.idx == 5'(i))) begin
				st_d.req_flag[i] = 1'b0;
			end
			if (trig[i]) begin
				st_d.req_flag[i] = 1'b1;
			end
		end
		if (wdt_nmi) begin
			st_d.nmi_pend = 1'b1;
		end
		if (software_trap_instruction_in) begin
			st_d.trap_pend = 1'b1;
		end
		// Non-maskable first, then trap, then the maskable winner.
		if (!st_d.req) begin
			if (st_d.nmi_pend) begin
				st_d.req    = 1'b1;
				st_d.kind   = VIC_KIND_NMI;
				st_d.vector = VIC_VEC_NMI;
				st_d.level_hi = 1'b1;
			end else if (st_d.trap_pend) begin
				st_d.req    = 1'b1;
				st_d.kind   = VIC_KIND_TRAP;
				st_d.vector = VIC_VEC_TRAP;
				st_d.level_hi = 1'b0;
			end else if (sel_bus.found && !(st_q.req && irq_ack_in)) begin
				st_d.req      = 1'b1;
				st_d.kind     = VIC_KIND_MASK;
				st_d.idx      = sel_bus.idx;
				st_d.vector   = vic_vector(sel_bus.idx);
				st_d.level_hi = sel_bus.idx_hi;
			end else begin
				st_d.kind = VIC_KIND_NONE;
			end
		end
		if (sys_rst_in) begin
			st_d = VIC_RST;
		end
	end

	// Single register stage for the whole state.
	always_ff @(posedge clk_in) begin
		st_q <= st_d;
	end

	assign irq_req_out       = st_q.req;
	assign irq_kind_out      = st_q.kind;
	assign irq_vector_out    = st_q.vector;
	assign irq_level_hi_out  = st_q.level_hi;
	assign request_flags_out = st_q.req_flag;

	// ==========================================================
	// Checks.
	// ==========================================================
	a_nmi_vector_taken: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(watchdog_overflow_irq_in && wdt_mode_in && !st_q.req) |=> (irq_req_out && irq_vector_out == 16'h0004))
		else $error("NMI not presented at 0004H");

	a_wdt_mode_exclusive: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(watchdog_overflow_irq_in && wdt_mode_in) |=> !$rose(request_flags_out[0]))
		else $error("Watchdog flag set in mode one");

	a_wdt_interval_flag: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(watchdog_overflow_irq_in && !wdt_mode_in) |=> request_flags_out[0])
		else $error("Interval watchdog flag not set");

	a_ext_edge_flag: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		$rose(external_edge_irqs_in[0]) |-> ##3 request_flags_out[1])
		else $error("External edge flag not set after sync");

	a_slot_ten_empty: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		!request_flags_out[10] && !(irq_req_out && irq_vector_out == 16'h0018))
		else $error("Empty slot used");

	a_trap_vector: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(software_trap_instruction_in && !st_q.req && !st_q.nmi_pend && !wdt_nmi)
		|=> (irq_kind_out == 2'b11 && irq_vector_out == 16'h003E))
		else $error("Trap vector not presented");

	a_mask_blocks_req: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(irq_req_out && irq_kind_out == 2'b10 && $changed(irq_vector_out)) |-> $past(global_enable_flag_in))
		else $error("Maskable presented while disabled");

	a_key_vector: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(irq_req_out && irq_kind_out == 2'b10 && st_q.idx == 5'h06) |-> irq_vector_out == 16'h0010)
		else $error("Key vector wrong");

	a_tx_vector: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(irq_req_out && irq_kind_out == 2'b10 && st_q.idx == 5'h10) |-> irq_vector_out == 16'h0024)
		else $error("Transmit vector wrong");

	a_ack_clears_flag: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(irq_req_out && irq_ack_in && irq_kind_out == 2'b10 && !trig[st_q.idx])
		|=> !request_flags_out[$past(st_q.idx)])
		else $error("Acknowledge left flag set");

	a_hold_until_ack: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(irq_req_out && !irq_ack_in) |=> (irq_req_out && $stable(irq_vector_out)))
		else $error("Vector changed before acknowledge");

	// ==========================================================
	// Vector checks per maskable source, and the last external edge flag.
	// ==========================================================
	// Each expected vector is written out by hand. A shared formula here would
	// repeat any slip in the mapping function and hide it.
	a_wdt_mask_vector: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(irq_req_out && irq_kind_out == 2'b10 && st_q.idx == 5'h00) |-> irq_vector_out == 16'h0004)
		else $error("Interval watchdog vector wrong");

	a_ext0_vector: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(irq_req_out && irq_kind_out == 2'b10 && st_q.idx == 5'h01) |-> irq_vector_out == 16'h0006)
		else $error("First external vector wrong");

	a_ext1_vector: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(irq_req_out && irq_kind_out == 2'b10 && st_q.idx == 5'h02) |-> irq_vector_out == 16'h0008)
		else $error("Second external vector wrong");

	a_ext2_vector: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(irq_req_out && irq_kind_out == 2'b10 && st_q.idx == 5'h03) |-> irq_vector_out == 16'h000A)
		else $error("Third external vector wrong");

	a_ext3_vector: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(irq_req_out && irq_kind_out == 2'b10 && st_q.idx == 5'h04) |-> irq_vector_out == 16'h000C)
		else $error("Fourth external vector wrong");

	a_ext4_vector: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(irq_req_out && irq_kind_out == 2'b10 && st_q.idx == 5'h05) |-> irq_vector_out == 16'h000E)
		else $error("Fifth external vector wrong");

	a_ext_edge_last: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		$rose(external_edge_irqs_in[4]) |-> ##3 request_flags_out[5])
		else $error("Fifth external flag not set after sync");

	a_i2c_vector: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(irq_req_out && irq_kind_out == 2'b10 && st_q.idx == 5'h07) |-> irq_vector_out == 16'h0012)
		else $error("I2C vector wrong");

	a_btm_vector: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(irq_req_out && irq_kind_out == 2'b10 && st_q.idx == 5'h08) |-> irq_vector_out == 16'h0014)
		else $error("Basic timer vector wrong");

	a_adc_vector: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(irq_req_out && irq_kind_out == 2'b10 && st_q.idx == 5'h09) |-> irq_vector_out == 16'h0016)
		else $error("Converter vector wrong");

	a_three_wire_vector: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(irq_req_out && irq_kind_out == 2'b10 && st_q.idx == 5'h0B) |-> irq_vector_out == 16'h001A)
		else $error("Three-wire vector wrong");

	a_tma_vector: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(irq_req_out && irq_kind_out == 2'b10 && st_q.idx == 5'h0C) |-> irq_vector_out == 16'h001C)
		else $error("First timer vector wrong");

	a_tmb_vector: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(irq_req_out && irq_kind_out == 2'b10 && st_q.idx == 5'h0D) |-> irq_vector_out == 16'h001E)
		else $error("Second timer vector wrong");

	a_rx_error_vector: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(irq_req_out && irq_kind_out == 2'b10 && st_q.idx == 5'h0E) |-> irq_vector_out == 16'h0020)
		else $error("Receive error vector wrong");

	a_rx_done_vector: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(irq_req_out && irq_kind_out == 2'b10 && st_q.idx == 5'h0F) |-> irq_vector_out == 16'h0022)
		else $error("Receive done vector wrong");

	// ==========================================================
	// Presentation checks.
	// ==========================================================
	// The kind code must always match the vector, or the core would enter the
	// wrong handler with the right address.
	a_nmi_kind_vector: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(irq_req_out && irq_kind_out == 2'b01) |-> (irq_vector_out == 16'h0004 && irq_level_hi_out))
		else $error("NMI presented with wrong vector or level");

	a_trap_kind_vector: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(irq_req_out && irq_kind_out == 2'b11) |-> irq_vector_out == 16'h003E)
		else $error("Trap presented with wrong vector");

	a_idle_kind_none: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		!irq_req_out |-> irq_kind_out == 2'b00)
		else $error("Kind shown while idle");

	a_req_has_kind: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		irq_req_out |-> irq_kind_out != 2'b00)
		else $error("Request shown without kind");

	a_ack_releases_req: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(irq_req_out && irq_ack_in && irq_kind_out == 2'b10 && !st_q.nmi_pend && !st_q.trap_pend
		 && !wdt_nmi && !software_trap_instruction_in) |=> !irq_req_out)
		else $error("Request not released after acknowledge");

	a_isp_blocks_low: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(irq_req_out && irq_kind_out == 2'b10 && $rose(irq_req_out) && $past(in_service_level_flag_in))
		|-> irq_level_hi_out)
		else $error("Low group presented during high service");

	a_rst_clears_all: assert property (@(posedge clk_in)
		sys_rst_in |=> (!irq_req_out && request_flags_out == 17'h00000))
		else $error("Reset left a request standing");

endmodule // vic_top

`default_nettype wire

// >>> verif/vic_core_model.sv
`timescale 1ns/1ps
`default_nettype none

// ====================================================
// Core model: accepts presented vectors and logs them.
// ====================================================
module vic_core_model (
	input  wire logic        clk_in,
	input  wire logic        sys_rst_in,
	input  wire logic        ack_en_in,
	input  wire logic        irq_req_in,
	input  wire logic [1:0]  irq_kind_in,
	input  wire logic [15:0] irq_vector_in,
	output logic             irq_ack_out,
	output logic             taken_out,
	output logic [17:0]      taken_val_out
);
	// The ack stands one cycle only, so a stale vector is never taken twice.
	// Holding ack_en_in low stalls the core like a slow interrupt entry.
	always_ff @(posedge clk_in) begin
		taken_out <= 1'b0;
		if (sys_rst_in) begin
			irq_ack_out <= 1'b0;
		end else if (irq_ack_out) begin
			irq_ack_out   <= 1'b0;
			taken_out     <= irq_req_in;
			taken_val_out <= {irq_kind_in, irq_vector_in};
		end else begin
			irq_ack_out <= irq_req_in & ack_en_in;
		end
	end
endmodule // vic_core_model

`default_nettype wire

// >>> verif/vic_top_test.sv
`timescale 1ns/1ps
`default_nettype none

module vic_top_test;
	import vic_pkg::*;
	logic        clk_in = 1'b0;
	logic        rst = 1'b1;
	logic [16:0] src = '0;
	logic        trap = 1'b0;
	logic        mode = 1'b0;
	logic        gen = 1'b1;
	logic        in_service_level_flag = 1'b0;
	logic        ack_en = 1'b1;
	logic [16:0] mask = '0;
	logic [16:0] lvl = '0;
	logic        irq_ack, irq_req_out, irq_level_hi_out, taken;
	logic [1:0]  irq_kind_out;
	logic [15:0] irq_vector_out;
	logic [16:0] request_flags_out;
	logic [17:0] taken_val;
	logic [17:0] taken_q[$];
	int          err_count = 0;
	int          total_checks = 0;
	int          cyc = 0;

	// ====================================================
	// Clock, design and core model.
	// ====================================================
	initial begin
		forever #12.5 clk_in = ~clk_in;
	end

	vic_top i_dut (.clk_in(clk_in), .sys_rst_in(rst), .wdt_mode_in(mode),
		.watchdog_overflow_irq_in(src[0]), .external_edge_irqs_in(src[5:1]),
		.key_input_irq_in(src[6]), .i2c_transfer_done_irq_in(src[7]),
		.basic_timer_match_irq_in(src[8]), .adc_conversion_done_irq_in(src[9]),
		.three_wire_transfer_done_irq_in(src[11]), .timer_a_match_irq_in(src[12]),
		.timer_b_match_irq_in(src[13]), .async_rx_error_irq_in(src[14]),
		.async_rx_done_irq_in(src[15]), .async_tx_done_irq_in(src[16]),
		.software_trap_instruction_in(trap), .global_enable_flag_in(gen),
		.in_service_level_flag_in(in_service_level_flag), .mask_flag_in(mask), .level_select_flag_in(lvl),
		.irq_ack_in(irq_ack), .irq_req_out(irq_req_out), .irq_kind_out(irq_kind_out),
		.irq_vector_out(irq_vector_out), .irq_level_hi_out(irq_level_hi_out),
		.request_flags_out(request_flags_out));

	vic_core_model i_core (.clk_in(clk_in), .sys_rst_in(rst), .ack_en_in(ack_en),
		.irq_req_in(irq_req_out), .irq_kind_in(irq_kind_out), .irq_vector_in(irq_vector_out),
		.irq_ack_out(irq_ack), .taken_out(taken), .taken_val_out(taken_val));

	// The log and the hang limit share the clock; the limit is far above the run.
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (taken === 1'b1) begin
			taken_q.push_back(taken_val);
		end
		if (cyc == 5000) begin
			err_count++;
			complete_run();
		end
	end

	// ====================================================
	// Shared tasks.
	// ====================================================
	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	function automatic logic [15:0] exp_vec(input int i);
		return (i == 0) ? 16'h0004 : 16'h0006 + 16'(2 * (i - 1));
	endfunction

	// Internal bits pulse one cycle; edge pins stay high long enough to sync.
	task automatic pulse(input logic [16:0] m);
		@(posedge clk_in) src <= m;
		@(posedge clk_in) src <= m & 17'h0003E;
		repeat (3) @(posedge clk_in);
		src <= '0;
	endtask

	task automatic expect_take(input logic [1:0] k, input logic [15:0] v);
		int          n;
		logic [17:0] e;
		n = 0;
		while (taken_q.size() == 0 && n < 60) begin
			@(posedge clk_in);
			n++;
		end
		e = (taken_q.size() != 0) ? taken_q.pop_front() : 18'bx;
		check(e, {k, v});
	endtask

	task automatic expect_none();
		repeat (8) @(posedge clk_in);
		@(negedge clk_in);
		check({irq_req_out, 32'(taken_q.size())}, 40'h0);
	endtask

	// ====================================================
	// Scenarios.
	// ====================================================
	task automatic t_each();
		for (int i = 0; i < 17; i++) begin
			if (i != 10) begin
				pulse(17'h00001 << i);
				expect_take(2'h2, exp_vec(i));
			end
		end
		@(negedge clk_in);
		check(request_flags_out, 17'h0);
		$display("each source done");
	endtask

	task automatic t_prio();
		int order[5] = '{0, 3, 9, 11, 16};
		@(posedge clk_in) ack_en <= 1'b0;
		pulse(17'h10A09);
		@(negedge clk_in);
		check(request_flags_out, 17'h10A09);
		check({irq_req_out, irq_kind_out, irq_vector_out}, {1'b1, 2'h2, 16'h0004});
		@(posedge clk_in) ack_en <= 1'b1;
		foreach (order[j]) expect_take(2'h2, exp_vec(order[j]));
		$display("priority done");
	endtask

	task automatic t_gate();
		@(posedge clk_in) gen <= 1'b0;
		pulse(17'h00100);
		expect_none();
		check(request_flags_out, 17'h00100);
		@(posedge clk_in) gen <= 1'b1;
		expect_take(2'h2, 16'h0014);
		@(posedge clk_in) mask <= 17'h01000;
		pulse(17'h01000);
		expect_none();
		@(posedge clk_in) mask <= '0;
		expect_take(2'h2, 16'h001C);
		@(negedge clk_in);
		check(request_flags_out, 17'h0);
		$display("gating done");
	endtask

	task automatic t_nmi_trap();
		@(posedge clk_in) mode <= 1'b1;
		gen <= 1'b0;
		mask <= 17'h1FFFF;
		pulse(17'h00001);
		expect_take(2'h1, 16'h0004);
		check(request_flags_out, 17'h0);
		@(posedge clk_in) trap <= 1'b1;
		@(posedge clk_in) trap <= 1'b0;
		expect_take(2'h3, 16'h003E);
		@(posedge clk_in) mode <= 1'b0;
		pulse(17'h00001);
		expect_none();
		check(request_flags_out, 17'h00001);
		@(posedge clk_in) gen <= 1'b1;
		mask <= '0;
		expect_take(2'h2, 16'h0004);
		$display("nmi and trap done");
	endtask

	task automatic t_level();
		@(posedge clk_in) ack_en <= 1'b0;
		in_service_level_flag <= 1'b1;
		lvl <= 17'h02000;
		pulse(17'h02080);
		@(negedge clk_in);
		check({irq_req_out, irq_level_hi_out, irq_vector_out}, {2'b11, 16'h001E});
		@(posedge clk_in) ack_en <= 1'b1;
		expect_take(2'h2, 16'h001E);
		expect_none();
		check(request_flags_out, 17'h00080);
		@(posedge clk_in) in_service_level_flag <= 1'b0;
		expect_take(2'h2, 16'h0012);
		$display("level done");
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (15) @(posedge clk_in);
		@(negedge clk_in);
		check({irq_req_out, irq_kind_out, irq_vector_out, irq_level_hi_out, request_flags_out}, 40'h0);
		@(posedge clk_in) rst <= 1'b0;
		t_each();
		t_prio();
		t_gate();
		t_nmi_trap();
		t_level();
		complete_run();
	end
endmodule // vic_top_test

`default_nettype wire
